// >>> rtl/dac_host.sv
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "dac_host_consts.svh"

module dac_host (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [`ADDR_W-1:0] adr_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	output logic                   dac_cs_n_o,
	output logic                   dac_wr_n_o,
	output logic                   latch_copy_strobe_n_o,
	output logic                   byte_order_select_o,
	output logic      [9:0]        dac_data_o
);
	dac_host_pkg::ctl_s        ctl;
	dac_host_pkg::seq_state_e  state_reg, state_next;
	logic [`CNT_W-1:0]         cnt_reg, cnt_next;
	logic                      step_reg, step_next;
	logic                      copy_op_reg, copy_op_next;
	logic                      busy;
	logic                      narrow;
	logic                      last_step;
	logic [9:0]                code;
	dac_host_pkg::pin_s        pin_reg, pin_next;

	dac_host_regs u_regs (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cyc_i  (cyc_i),
		.stb_i  (stb_i),
		.we_i   (we_i),
		.sel_i  (sel_i),
		.adr_i  (adr_i),
		.dat_i  (dat_i),
		.dat_o  (dat_o),
		.ack_o  (ack_o),
		.busy_i (busy),
		.ctl_o  (ctl)
	);

	// ===================================================
	// sequencer
	always_comb begin
		narrow = (ctl.mode == dac_host_pkg::MODE_AUTO8) ||
			(ctl.mode == dac_host_pkg::MODE_UPCTL8) ||
			(ctl.mode == dac_host_pkg::MODE_EXT8);
		// low six bits of the source word are never sent
		code = ctl.zero_chk ? `ZERO_CODE : ctl.word[`WORD_MSB:`CODE_LSB];
		busy = (state_reg != dac_host_pkg::ST_IDLE);
		// an eight-bit word needs a second write; a copy is one strobe
		last_step = copy_op_reg || !narrow || step_reg;
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		step_next    = step_reg;
		copy_op_next = copy_op_reg;
		case (state_reg)
			dac_host_pkg::ST_IDLE: begin
				// flow-through keeps the pins open, no strobe sequence
				if (ctl.mode != dac_host_pkg::MODE_FLOW && (ctl.go || ctl.copy)) begin
					state_next   = dac_host_pkg::ST_SETUP;
					cnt_next     = `SETUP_CYC - 4'h1;
					step_next    = 1'b0;
					copy_op_next = ctl.copy;
				end
			end
			dac_host_pkg::ST_SETUP: begin
				if (cnt_reg == 4'h0) begin
					state_next = dac_host_pkg::ST_PULSE;
					cnt_next   = `PULSE_CYC - 4'h1;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			dac_host_pkg::ST_PULSE: begin
				if (cnt_reg == 4'h0) begin
					state_next = dac_host_pkg::ST_HOLD;
					cnt_next   = `HOLD_CYC - 4'h1;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			dac_host_pkg::ST_HOLD: begin
				if (cnt_reg != 4'h0) begin
					cnt_next = cnt_reg - 4'h1;
				end else if (last_step) begin
					state_next = dac_host_pkg::ST_IDLE;
				end else begin
					state_next = dac_host_pkg::ST_SETUP;
					cnt_next   = `SETUP_CYC - 4'h1;
					step_next  = 1'b1;
				end
			end
			default: state_next = dac_host_pkg::ST_IDLE;
		endcase
	end

	// ===================================================
	// pin drive, computed from the next sequencer state
	always_comb begin
		pin_next = '{cs_n: 1'b1, wr_n: 1'b1, copy_n: 1'b1, bos: 1'b1, data: code};
		if (ctl.mode == dac_host_pkg::MODE_FLOW) begin
			// both buffers transparent, output tracks the word
			pin_next.cs_n   = 1'b0;
			pin_next.wr_n   = 1'b0;
			pin_next.copy_n = 1'b0;
		end else if (state_next == dac_host_pkg::ST_IDLE) begin
			pin_next.copy_n = 1'b1;
		end else if (copy_op_next) begin
			// chip select stays off so every converter on the strobe moves together
			pin_next.wr_n   = (state_next != dac_host_pkg::ST_PULSE);
			pin_next.copy_n = (state_next != dac_host_pkg::ST_PULSE);
		end else begin
			pin_next.cs_n = 1'b0;
			pin_next.wr_n = (state_next != dac_host_pkg::ST_PULSE);
			// high byte group first, then the two low bits
			pin_next.bos  = narrow ? !step_next : 1'b1;
			// copy rides with the last write only in auto and single modes
			pin_next.copy_n = !((state_next == dac_host_pkg::ST_PULSE) &&
				(((ctl.mode == dac_host_pkg::MODE_AUTO8) && step_next) ||
				(ctl.mode == dac_host_pkg::MODE_SINGLE)));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg   <= dac_host_pkg::ST_IDLE;
			cnt_reg     <= 4'h0;
			step_reg    <= 1'b0;
			copy_op_reg <= 1'b0;
			pin_reg     <= '{cs_n: 1'b1, wr_n: 1'b1, copy_n: 1'b1, bos: 1'b1, data: 10'h000};
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			step_reg    <= step_next;
			copy_op_reg <= copy_op_next;
			pin_reg     <= pin_next;
		end
	end

	assign dac_cs_n_o            = pin_reg.cs_n;
	assign dac_wr_n_o            = pin_reg.wr_n;
	assign latch_copy_strobe_n_o = pin_reg.copy_n;
	assign byte_order_select_o   = pin_reg.bos;
	assign dac_data_o            = pin_reg.data;

	// ===================================================
	// checks
	// pins and sequencer state move on the same edge, so they are compared directly
	logic is_flow, is_narrow_word;
	assign is_flow        = (ctl.mode == dac_host_pkg::MODE_FLOW);
	assign is_narrow_word = narrow && !copy_op_reg && !dac_cs_n_o;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_two_writes: assert property (
		is_narrow_word && $rose(dac_wr_n_o) && !step_reg |-> ##[1:8] !dac_wr_n_o)
		else $error("second byte write missing");
	a_hi_first: assert property (
		is_narrow_word && $fell(dac_wr_n_o) |-> byte_order_select_o == !step_reg)
		else $error("byte order wrong");
	a_wide_bos: assert property (
		!narrow && !is_flow && !dac_cs_n_o |-> byte_order_select_o)
		else $error("byte select low on wide bus");
	a_pulse_width: assert property (
		!is_flow && $fell(dac_wr_n_o) |-> !dac_wr_n_o [*3] ##1 dac_wr_n_o)
		else $error("write pulse width");
	a_data_stable: assert property (
		!is_flow && !dac_wr_n_o && $past(!dac_wr_n_o) |-> $stable(dac_data_o))
		else $error("data moved under strobe");
	a_auto_copy: assert property (
		ctl.mode == dac_host_pkg::MODE_AUTO8 && is_narrow_word && !dac_wr_n_o
		|-> latch_copy_strobe_n_o == !step_reg)
		else $error("auto copy strobe misplaced");
	a_proc_nocopy: assert property (
		(ctl.mode == dac_host_pkg::MODE_UPCTL8 || ctl.mode == dac_host_pkg::MODE_EXT8)
		&& is_narrow_word |-> latch_copy_strobe_n_o)
		else $error("copy during byte load");
	a_copy_nocs: assert property (
		!is_flow && !latch_copy_strobe_n_o && copy_op_reg |-> dac_cs_n_o && !dac_wr_n_o)
		else $error("shared copy strobe form");
	a_zero_code: assert property (
		ctl.zero_chk && !dac_wr_n_o && !is_flow |-> dac_data_o == `ZERO_CODE)
		else $error("zero check code wrong");
	// leaving flow-through, the pins still show the old mode for one cycle
	a_idle_quiet: assert property (
		state_reg == dac_host_pkg::ST_IDLE && !is_flow && !$past(is_flow)
		|-> dac_cs_n_o && dac_wr_n_o && latch_copy_strobe_n_o)
		else $error("strobe active while idle");
	a_copy_width: assert property (
		!is_flow && copy_op_reg && $fell(latch_copy_strobe_n_o)
		|-> !latch_copy_strobe_n_o [*3] ##1 latch_copy_strobe_n_o)
		else $error("copy strobe width");
	// chip select must already stand when the write strobe falls
	a_cs_setup: assert property (
		!is_flow && !copy_op_reg && $fell(dac_wr_n_o) |-> $past(!dac_cs_n_o))
		else $error("chip select setup short");

	c_auto: cover property (ctl.mode == dac_host_pkg::MODE_AUTO8 && !latch_copy_strobe_n_o);
	c_copy: cover property (copy_op_reg && !latch_copy_strobe_n_o);
	c_single: cover property (ctl.mode == dac_host_pkg::MODE_SINGLE && !dac_wr_n_o);
	c_flow: cover property (is_flow && !dac_cs_n_o);
	c_two_byte: cover property (is_narrow_word && !byte_order_select_o && !dac_wr_n_o);

endmodule : dac_host

// >>> rtl/dac_host_consts.svh
`ifndef DAC_HOST_CONSTS_SVH
`define DAC_HOST_CONSTS_SVH

// ===================================================
// register map (byte addresses, one word each)
`define REG_CTRL_OFS     4'h0
`define REG_WORD_OFS     4'h4
`define REG_COPY_OFS     4'h8
`define REG_STATUS_OFS   4'hC
`define ADDR_W           4

// ===================================================
// field positions
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    2
`define CTRL_ZERO_BIT    3
`define COPY_GO_BIT      0
`define STATUS_BUSY_BIT  0
`define WORD_MSB         15
`define CODE_LSB         6
`define CODE_W           10

// ===================================================
// reset values and the zero-check code
`define CTRL_MODE_RST    3'h0
`define WORD_RST         16'h0000
`define ZERO_CODE        10'h200

// ===================================================
// strobe timing at the system clock
`define CLK_MHZ          10
`define SETUP_NS         100
`define PULSE_NS         300
`define HOLD_NS          100
`define NS_TO_CYC(ns)    ((((ns) * `CLK_MHZ) + 999) / 1000)
`define SETUP_CYC        4'(`NS_TO_CYC(`SETUP_NS))
`define PULSE_CYC        4'(`NS_TO_CYC(`PULSE_NS))
`define HOLD_CYC         4'(`NS_TO_CYC(`HOLD_NS))
`define CNT_W            4

`endif

// >>> rtl/dac_host_pkg.sv
package dac_host_pkg;

	typedef enum logic [2:0] {
		MODE_AUTO8   = 3'b000,
		MODE_UPCTL8  = 3'b001,
		MODE_EXT8    = 3'b010,
		MODE_SINGLE  = 3'b011,
		MODE_DOUBLE  = 3'b100,
		MODE_FLOW    = 3'b101
	} mode_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_PULSE = 2'b10,
		ST_HOLD  = 2'b11
	} seq_state_e;

	typedef struct packed {
		logic       cs_n;
		logic       wr_n;
		logic       copy_n;
		logic       bos;
		logic [9:0] data;
	} pin_s;

	typedef struct packed {
		mode_e       mode;
		logic        zero_chk;
		logic [15:0] word;
		logic        go;
		logic        copy;
	} ctl_s;

endpackage : dac_host_pkg

// >>> rtl/dac_host_regs.sv
`timescale 1ns/10ps
`include "dac_host_consts.svh"

module dac_host_regs (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [`ADDR_W-1:0]   adr_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	input  wire logic                 busy_i,
	output dac_host_pkg::ctl_s        ctl_o
);
	dac_host_pkg::ctl_s ctl_reg, ctl_next;
	logic               ack_reg, ack_next;
	logic [31:0]        dat_reg, dat_next;
	logic               req;

	// ===================================================
	// classic slave: one wait state, ack drops after one cycle
	always_comb begin
		req      = cyc_i && stb_i && !ack_reg;
		ack_next = req;
		dat_next = 32'h0000_0000;
		ctl_next = ctl_reg;
		ctl_next.go   = 1'b0;
		ctl_next.copy = 1'b0;
		if (req && we_i) begin
			case (adr_i)
				`REG_CTRL_OFS: begin
					if (sel_i[0]) begin
						ctl_next.mode     = dac_host_pkg::mode_e'(dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
						ctl_next.zero_chk = dat_i[`CTRL_ZERO_BIT];
					end
				end
				`REG_WORD_OFS: begin
					// words arriving while busy are dropped; status shows why
					if (!busy_i) begin
						if (sel_i[0]) ctl_next.word[7:0] = dat_i[7:0];
						if (sel_i[1]) ctl_next.word[15:8] = dat_i[15:8];
						ctl_next.go = 1'b1;
					end
				end
				`REG_COPY_OFS: begin
					if (sel_i[0] && dat_i[`COPY_GO_BIT] && !busy_i) ctl_next.copy = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (req) begin
			case (adr_i)
				`REG_CTRL_OFS:   dat_next = {28'h0000000, ctl_reg.zero_chk, 3'(ctl_reg.mode)};
				`REG_WORD_OFS:   dat_next = {16'h0000, ctl_reg.word};
				`REG_STATUS_OFS: dat_next = {31'h00000000, busy_i};
				default:         dat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			ctl_reg <= '{mode: dac_host_pkg::mode_e'(`CTRL_MODE_RST), zero_chk: 1'b0,
				word: `WORD_RST, go: 1'b0, copy: 1'b0};
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			ctl_reg <= ctl_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign ctl_o = ctl_reg;

endmodule : dac_host_regs

// >>> test/dac_model.sv
`timescale 1ns/10ps
// ==========================================
// converter digital input: input latch then converter register
module dac_model (
	input  wire logic       cs_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       copy_n_i,
	input  wire logic       bos_i,
	input  wire logic [9:0] data_i,
	output logic      [9:0] latch_o,
	output logic      [9:0] out_o
);
	// level sensitive, as the real part: all strobes low means flow-through
	always_latch begin
		if (!cs_n_i && !wr_n_i) begin
			if (bos_i) begin
				latch_o = data_i;
			end else begin
				latch_o[1:0] = data_i[1:0];
			end
		end
	end

	// cs not needed here so one shared copy strobe can serve many parts
	always_latch begin
		if (!wr_n_i && !copy_n_i) begin
			out_o = latch_o;
		end
	end
endmodule : dac_model

// >>> test/dac_host_tb.sv
`timescale 1ns/10ps
`include "dac_host_consts.svh"
module dac_host_tb;
	logic                clk_i, ack_o, cs_n, wr_n, cp_n, bos;
	logic                rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0]          sel_i = 4'hF, adr_i = 4'h0;
	logic [31:0]         dat_i = 32'h0, dat_o, rd;
	logic [9:0]          pins, lat, aout, exp_out;
	logic [15:0]         w;
	dac_host_pkg::mode_e cur_mode = dac_host_pkg::MODE_AUTO8;
	int                  bad_count = 0, checks_done = 0;

	dac_host DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.dac_cs_n_o(cs_n), .dac_wr_n_o(wr_n), .latch_copy_strobe_n_o(cp_n),
		.byte_order_select_o(bos), .dac_data_o(pins));
	dac_model far (.cs_n_i(cs_n), .wr_n_i(wr_n), .copy_n_i(cp_n), .bos_i(bos),
		.data_i(pins), .latch_o(lat), .out_o(aout));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ==========================================
	// helpers
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		sel_i <= 4'hF;
		we_i  <= wr;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		if (n >= 50) begin
			bad_count++;
			stop_test();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic idle;
		int n;
		n = 0;
		do begin
			wb(1'b0, `REG_STATUS_OFS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 50);
		// a sequencer that never goes idle ends the run here
		if (rd[0] !== 1'b0) begin
			bad_count++;
			stop_test();
		end
	endtask : idle

	function automatic logic [9:0] code(logic [15:0] wd, logic z);
		return z ? 10'h200 : wd[15:6];
	endfunction : code

	// processor modes: 8-bit ones need no extra copy only in auto, wide single likewise
	task automatic op(input dac_host_pkg::mode_e m, input logic z, input logic [15:0] wd);
		cur_mode = m;
		wb(1'b1, `REG_CTRL_OFS, {28'h0, z, m});
		wb(1'b1, `REG_WORD_OFS, {16'h0, wd});
		idle();
		chk("latch", code(wd, z), lat);
		if (m == dac_host_pkg::MODE_AUTO8 || m == dac_host_pkg::MODE_SINGLE) begin
			exp_out = code(wd, z);
			chk("auto_out", exp_out, aout);
		end else begin
			chk("held_out", exp_out, aout);
			wb(1'b1, `REG_COPY_OFS, 32'h1);
			idle();
			exp_out = code(wd, z);
			chk("copied_out", exp_out, aout);
		end
	endtask : op

	// first byte must leave the output alone
	always @(negedge bos) begin
		if (cur_mode != dac_host_pkg::MODE_FLOW) chk("first_byte_out", exp_out, aout);
	end

	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'hE984));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("idle_pins", {18'h0, 4'hF, 10'h000}, {cs_n, wr_n, cp_n, bos, pins});
		wb(1'b0, `REG_CTRL_OFS, 32'h0);
		chk("ctrl_reset", 32'h0, rd);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		op(dac_host_pkg::MODE_SINGLE, 1'b1, 16'($urandom));
		for (int i = 0; i < 15; i++) begin
			w = (i == 0) ? 16'h003F : (i == 1) ? 16'hFFFF : 16'($urandom);
			op(dac_host_pkg::mode_e'(3'(i % 5)), 1'b0, w);
		end
		// second word arrives while busy and must be dropped
		cur_mode = dac_host_pkg::MODE_AUTO8;
		wb(1'b1, `REG_CTRL_OFS, 32'h0);
		w = 16'($urandom);
		wb(1'b1, `REG_WORD_OFS, {16'h0, w});
		wb(1'b1, `REG_WORD_OFS, {16'h0, ~w});
		idle();
		exp_out = w[15:6];
		chk("busy_drop", exp_out, aout);
		cur_mode = dac_host_pkg::MODE_FLOW;
		w = 16'($urandom);
		wb(1'b1, `REG_CTRL_OFS, 32'h5);
		wb(1'b1, `REG_WORD_OFS, {16'h0, w});
		repeat (3) @(posedge clk_i);
		chk("flow_out", {22'h0, w[15:6]}, aout);
		stop_test();
	end
endmodule : dac_host_tb
